// ### sbf_framer.sv
// sample block framer: transmit word parser, time hold, end status, rx packer
`timescale 1ns/100ps
`include "sbf_regs.svh"
module sbf_framer
  import sbf_pkg::*;
(
  input wire logic ref_clk_in, // 20 MHz clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic sample_tick_in, // one-cycle pulse per sample period
  input wire logic tx_valid_in, // transmit fifo holds a word
  input wire logic [15:0] tx_word_in, // transmit fifo head word
  output logic tx_pop_out, // takes the head word this cycle
  output sbf_tx_samp_t tx_samp_out, // samples to output converters
  output logic tx_samp_stb_out, // one-cycle pulse: new output sample
  input wire logic reg_rd_in, // register read strobe
  input wire logic [7:0] reg_addr_in, // register address
  output logic [15:0] reg_rdata_out, // read data, one cycle after strobe
  output logic tx_done_out, // transmit done status level
  input wire logic rx_valid_in, // one-cycle pulse: new input samples
  input wire logic [2:0] rx_type_in, // requested receive block type
  input wire sbf_rx_samp_t rx_samp_in, // input sample set
  input wire logic rx_ready_in, // receive fifo accepts a word
  output logic rx_samp_ready_out, // receive packer idle
  output logic rx_word_valid_out, // receive word valid
  output logic [15:0] rx_word_out // receive fifo word
);
  sbf_tx_st_t s_q, s_d;
  logic [15:0] w;
  logic sync;
  logic resync;
  logic [1:0] i;
  logic [2:0] t;
  logic [2:0] len;
  logic release_ok;

  assign w = tx_word_in;
  assign sync = w[`SBF_SYNC_BIT];
  // a held block may leave only on the matching sample number
  assign release_ok = !s_q.hold || (s_q.cnt == s_q.tgt);

  // ----------------------------------------------------------------
  // transmit word parsing
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.out_stb = 1'b0;
    resync = 1'b0;
    i = s_q.idx;
    t = s_q.btype;
    len = `SBF_TX_LEN_PAIR;
    // a pop is issued only every other cycle so the head word is stable
    s_d.pop = (s_q.state == SBF_TX_COLLECT) && tx_valid_in && !s_q.pop;
    if (s_q.pop) begin
      // the sync bit is looked at on every word, control byte or not
      resync = s_q.prev_sync && !sync;
      if (resync) begin
        // previous word was the block head: rebuild from it
        i = 2'h1;
        t = s_q.prev_type;
        s_d.bytes[0] = s_q.prev_byte;
      end else if (i == 2'h0 && sync) begin
        t = w[`SBF_TYPE_HI:`SBF_TYPE_LO];
      end
      // data-only words keep the last known type, so counting carries on
      case (t)
        `SBF_TX_PAIR: len = `SBF_TX_LEN_PAIR;
        `SBF_TX_END: len = `SBF_TX_LEN_END;
        default: len = `SBF_TX_LEN_TWO;
      endcase
      s_d.btype = t;
      s_d.bytes[i] = w[7:0];
      s_d.prev_sync = sync;
      s_d.prev_byte = w[7:0];
      s_d.prev_type = w[`SBF_TYPE_HI:`SBF_TYPE_LO];
      if ({1'b0, i} + 3'h1 >= len) begin
        s_d.idx = 2'h0;
        case (t)
          `SBF_TX_PAIR, `SBF_TX_A_ONLY, `SBF_TX_B_ONLY: begin
            s_d.state = SBF_TX_READY;
          end
          `SBF_TX_TIME: begin
            s_d.hold = 1'b1;
            s_d.tgt = {s_d.bytes[0], w[7:0]};
          end
          `SBF_TX_END: begin
            // preceding samples are already out: parsing stalls while one waits
            s_d.done = 1'b1;
          end
          default: s_d.idx = 2'h0;
        endcase
      end else begin
        s_d.idx = i + 2'h1;
      end
    end
    // ----------------------------------------------------------------
    // sample output, once per sample period
    // ----------------------------------------------------------------
    if (sample_tick_in) begin
      s_d.cnt = s_q.cnt + 16'h1;
      if (s_q.state == SBF_TX_READY && release_ok) begin
        s_d.hold = 1'b0;
        s_d.state = SBF_TX_COLLECT;
        s_d.out_stb = 1'b1;
        s_d.out.en_a = (s_q.btype != `SBF_TX_B_ONLY);
        s_d.out.en_b = (s_q.btype != `SBF_TX_A_ONLY);
        if (s_q.btype == `SBF_TX_B_ONLY) begin
          s_d.out.out_converter_b = {s_q.bytes[0], s_q.bytes[1]};
        end else begin
          s_d.out.out_converter_a = {s_q.bytes[0], s_q.bytes[1]};
          if (s_q.btype == `SBF_TX_PAIR) begin
            s_d.out.out_converter_b = {s_q.bytes[2], s_q.bytes[3]};
          end
        end
      end
    end
    // ----------------------------------------------------------------
    // register reads; status read clears done, a new set wins
    // ----------------------------------------------------------------
    s_d.rdata = 16'h0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `SBF_SAMPLE_TIME_OFS: s_d.rdata = s_q.cnt;
        `SBF_IRQ_STATUS_OFS: begin
          s_d.rdata[`SBF_IRQ_TX_DONE_BIT] = s_q.done;
          if (!(s_q.pop && ({1'b0, i} + 3'h1 >= len) && t == `SBF_TX_END)) begin
            s_d.done = 1'b0;
          end
        end
        default: s_d.rdata = 16'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_pop_out = s_q.pop;
  assign tx_samp_out = s_q.out;
  assign tx_samp_stb_out = s_q.out_stb;
  assign reg_rdata_out = s_q.rdata;
  assign tx_done_out = s_q.done;

  // ----------------------------------------------------------------
  // receive packing
  // ----------------------------------------------------------------
  sbf_rx_packer u_rx (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .samp_valid_in(rx_valid_in),
    .samp_type_in(rx_type_in),
    .samp_in(rx_samp_in),
    .samp_num_in(s_q.cnt),
    .word_ready_in(rx_ready_in),
    .samp_ready_out(rx_samp_ready_out),
    .word_valid_out(rx_word_valid_out),
    .word_out(rx_word_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_hold_blocks_out: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.hold && sample_tick_in && s_q.cnt != s_q.tgt) |=> !tx_samp_stb_out)
    else $error("sample output while time hold active");
  chk_match_resumes: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.hold && s_q.state == SBF_TX_READY && sample_tick_in && s_q.cnt == s_q.tgt)
      |=> tx_samp_stb_out && !s_q.hold)
    else $error("no output on matching sample number");
  chk_time_load: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.pop && t == `SBF_TX_TIME && i == 2'h1)
      |=> s_q.hold && s_q.tgt[7:0] == $past(tx_word_in[7:0]))
    else $error("time block not loaded into hold");
  chk_resync_index: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.pop && s_q.prev_sync && !tx_word_in[15] && s_q.prev_type == `SBF_TX_PAIR)
      |=> s_q.idx == 2'h2)
    else $error("sync falling edge did not restart block");
  chk_count_wrap: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.pop && !resync && !sync && s_q.btype == `SBF_TX_A_ONLY && s_q.idx == 2'h1)
      |=> s_q.idx == 2'h0 && s_q.state == SBF_TX_READY)
    else $error("data-only block not closed at its length");
  chk_time_reg: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (reg_rd_in && reg_addr_in == `SBF_SAMPLE_TIME_OFS) |=> reg_rdata_out == $past(s_q.cnt))
    else $error("sample time register mismatch");
  chk_done_set: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.pop && !resync && sync && tx_word_in[10:8] == `SBF_TX_END && s_q.idx == 2'h0)
      |=> tx_done_out)
    else $error("end block did not set transmit done");
  chk_pop_stall: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.state == SBF_TX_READY) |-> ##1 !tx_pop_out)
    else $error("word taken while a sample waits");
endmodule

// ### sbf_regs.svh
// register offsets, field positions and codes for the sample block framer
`ifndef SBF_REGS_SVH
`define SBF_REGS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SBF_TX_FIFO_DATA_CONTROL_OFS 8'h48
`define SBF_SAMPLE_TIME_OFS 8'h7d
`define SBF_IRQ_STATUS_OFS 8'h7e
`define SBF_IRQ_TX_DONE_BIT 0
// ----------------------------------------------------------------
// word fields
// ----------------------------------------------------------------
`define SBF_SYNC_BIT 15
`define SBF_TYPE_HI 10
`define SBF_TYPE_LO 8
// ----------------------------------------------------------------
// transmit block types and lengths in words
// ----------------------------------------------------------------
`define SBF_TX_PAIR 3'h0
`define SBF_TX_A_ONLY 3'h1
`define SBF_TX_B_ONLY 3'h2
`define SBF_TX_END 3'h6
`define SBF_TX_TIME 3'h7
`define SBF_TX_LEN_PAIR 3'h4
`define SBF_TX_LEN_TWO 3'h2
`define SBF_TX_LEN_END 3'h1
// ----------------------------------------------------------------
// receive block types and lengths in words
// ----------------------------------------------------------------
`define SBF_RX_PAIR 3'h0
`define SBF_RX_A_ONLY 3'h1
`define SBF_RX_B_ONLY 3'h2
`define SBF_RX_PH_MAG 3'h4
`define SBF_RX_PHASE 3'h5
`define SBF_RX_MAG 3'h6
`define SBF_RX_ALL 3'h7
`define SBF_RX_LEN_TWO 4'h2
`define SBF_RX_LEN_FOUR 4'h4
`define SBF_RX_LEN_ALL 4'h8
`endif

// ### sbf_pkg.sv
// types shared by the sample block framer modules
package sbf_pkg;
  // ----------------------------------------------------------------
  // state encodings (gray along the usual path)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SBF_TX_COLLECT = 2'h0,
    SBF_TX_READY = 2'h1
  } sbf_tx_state_t;

  typedef enum logic [1:0] {
    SBF_RX_IDLE = 2'h0,
    SBF_RX_SEND = 2'h1
  } sbf_rx_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] in_converter_a;
    logic [15:0] in_converter_b;
    logic [15:0] phase;
    logic [15:0] magnitude;
  } sbf_rx_samp_t;

  typedef struct packed {
    logic [15:0] out_converter_a;
    logic [15:0] out_converter_b;
    logic en_a;
    logic en_b;
  } sbf_tx_samp_t;

  // ----------------------------------------------------------------
  // module state records
  // ----------------------------------------------------------------
  typedef struct packed {
    sbf_rx_state_t state;
    logic [7:0][7:0] bytes;
    logic [2:0] btype;
    logic [6:0] num;
    logic [3:0] len;
    logic [3:0] idx;
    logic [15:0] word;
    logic valid;
  } sbf_rx_st_t;

  typedef struct packed {
    sbf_tx_state_t state;
    logic hold;
    logic [15:0] tgt;
    logic [15:0] cnt;
    logic [1:0] idx;
    logic [2:0] btype;
    logic [3:0][7:0] bytes;
    logic prev_sync;
    logic [7:0] prev_byte;
    logic [2:0] prev_type;
    sbf_tx_samp_t out;
    logic out_stb;
    logic done;
    logic [15:0] rdata;
    logic pop;
  } sbf_tx_st_t;
endpackage

// ### sbf_rx_packer.sv
// receive side: packs converter samples into tagged sample blocks
`timescale 1ns/100ps
`include "sbf_regs.svh"
module sbf_rx_packer
  import sbf_pkg::*;
(
  input wire logic ref_clk_in, // 20 MHz clock
  input wire logic resetn_in, // synchronous reset, active low
  input wire logic samp_valid_in, // one-cycle pulse: new samples
  input wire logic [2:0] samp_type_in, // requested block type
  input wire sbf_rx_samp_t samp_in, // sample set
  input wire logic [15:0] samp_num_in, // running sample counter
  input wire logic word_ready_in, // receive fifo accepts a word
  output logic samp_ready_out, // idle, can take samples
  output logic word_valid_out, // receive word valid
  output logic [15:0] word_out // receive fifo word
);
  sbf_rx_st_t s_q, s_d;

  // ----------------------------------------------------------------
  // block build and word sequencing
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (s_q.valid && word_ready_in) begin
      s_d.valid = 1'b0;
    end
    case (s_q.state)
      SBF_RX_IDLE: begin
        if (samp_valid_in) begin
          s_d.btype = samp_in_type(samp_type_in);
          s_d.num = samp_num_in[6:0];
          s_d.idx = 4'h0;
          s_d.state = SBF_RX_SEND;
          // byte order: upper then lower, a, b, phase, magnitude
          case (samp_type_in)
            `SBF_RX_PAIR: begin
              s_d.bytes = {32'h0, samp_in.in_converter_b[7:0], samp_in.in_converter_b[15:8],
                           samp_in.in_converter_a[7:0], samp_in.in_converter_a[15:8]};
              s_d.len = `SBF_RX_LEN_FOUR;
            end
            `SBF_RX_A_ONLY: begin
              s_d.bytes = {48'h0, samp_in.in_converter_a[7:0], samp_in.in_converter_a[15:8]};
              s_d.len = `SBF_RX_LEN_TWO;
            end
            `SBF_RX_B_ONLY: begin
              s_d.bytes = {48'h0, samp_in.in_converter_b[7:0], samp_in.in_converter_b[15:8]};
              s_d.len = `SBF_RX_LEN_TWO;
            end
            `SBF_RX_PH_MAG: begin
              s_d.bytes = {32'h0, samp_in.magnitude[7:0], samp_in.magnitude[15:8],
                           samp_in.phase[7:0], samp_in.phase[15:8]};
              s_d.len = `SBF_RX_LEN_FOUR;
            end
            `SBF_RX_PHASE: begin
              s_d.bytes = {48'h0, samp_in.phase[7:0], samp_in.phase[15:8]};
              s_d.len = `SBF_RX_LEN_TWO;
            end
            `SBF_RX_MAG: begin
              s_d.bytes = {48'h0, samp_in.magnitude[7:0], samp_in.magnitude[15:8]};
              s_d.len = `SBF_RX_LEN_TWO;
            end
            default: begin
              s_d.bytes = {samp_in.magnitude[7:0], samp_in.magnitude[15:8],
                           samp_in.phase[7:0], samp_in.phase[15:8],
                           samp_in.in_converter_b[7:0], samp_in.in_converter_b[15:8],
                           samp_in.in_converter_a[7:0], samp_in.in_converter_a[15:8]};
              s_d.len = `SBF_RX_LEN_ALL;
            end
          endcase
        end
      end
      SBF_RX_SEND: begin
        // next word only once the previous one has been taken
        if (!s_q.valid || word_ready_in) begin
          s_d.valid = 1'b1;
          s_d.word = {1'b0, 7'h0, s_q.bytes[s_q.idx[2:0]]};
          if (s_q.idx == 4'h0) begin
            s_d.word[`SBF_SYNC_BIT] = 1'b1;
            s_d.word[`SBF_TYPE_HI:`SBF_TYPE_LO] = s_q.btype;
          end else if (s_q.idx == 4'h1) begin
            s_d.word[14:8] = s_q.num;
          end
          s_d.idx = s_q.idx + 4'h1;
          if (s_q.idx + 4'h1 == s_q.len) begin
            s_d.state = SBF_RX_IDLE;
          end
        end
      end
      default: s_d.state = SBF_RX_IDLE;
    endcase
  end

  // the type codes pass through unchanged; kept as a function for clarity
  function automatic logic [2:0] samp_in_type(input logic [2:0] t);
    samp_in_type = t;
  endfunction

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign samp_ready_out = (s_q.state == SBF_RX_IDLE);
  assign word_valid_out = s_q.valid;
  assign word_out = s_q.word;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_first_word_sync: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.state == SBF_RX_SEND && s_q.idx == 4'h0 && (!s_q.valid || word_ready_in))
      |=> word_out[`SBF_SYNC_BIT] && word_out[10:8] == $past(s_q.btype))
    else $error("first block word lacks sync or type");
  chk_later_word_clear: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.state == SBF_RX_SEND && s_q.idx != 4'h0 && (!s_q.valid || word_ready_in))
      |=> !word_out[`SBF_SYNC_BIT])
    else $error("sync set in later block word");
  chk_all_len_eight: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (s_q.state == SBF_RX_IDLE && samp_valid_in && samp_type_in == `SBF_RX_ALL)
      |=> s_q.len == `SBF_RX_LEN_ALL)
    else $error("combined block not eight words");
endmodule

// ### sbf_host_model.sv
// host processor model: feeds transmit fifo words and reads device registers
`timescale 1ns/100ps
module sbf_host_model (
  input wire logic clk_in, // framer clock
  input wire logic pop_in, // framer takes the head word
  input wire logic [15:0] rdata_in, // register read data
  output logic tx_valid_out, // a word waits in the fifo
  output logic [15:0] tx_word_out, // fifo head word
  output logic rd_out, // register read strobe
  output logic [7:0] addr_out // register address
);
  logic [15:0] q[$];
  logic [15:0] last;

  // ----------------------------------------------------------------
  // transmit fifo
  // ----------------------------------------------------------------
  initial begin
    last = 16'h0000;
    tx_valid_out = 1'b0;
    tx_word_out = 16'hffff;
    rd_out = 1'b0;
    addr_out = 8'h00;
  end

  // words go in as the host wrote them, control byte optional
  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask

  // head holds until taken; an empty fifo shows the inverse of the last word, not a stale copy
  always @(posedge clk_in) begin
    if (pop_in === 1'b1 && q.size() != 0) begin
      last = q.pop_front();
    end
    #1;
    tx_valid_out = q.size() != 0;
    tx_word_out = (q.size() != 0) ? q[0] : ~last;
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // strobe held for one edge; data taken while it stands, then one idle edge
  // so that back-to-back reads never move the strobe twice in one time step
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    rd_out = 1'b1;
    addr_out = a;
    @(posedge clk_in);
    #2;
    d = rdata_in;
    rd_out = 1'b0;
    addr_out = ~a;
    @(posedge clk_in);
    #2;
  endtask
endmodule

// ### test_sample_block_framer.sv
// self-checking bench for the sample block framer
`timescale 1ns/100ps
`include "sbf_regs.svh"
module test_sample_block_framer
  import sbf_pkg::*;
;
  logic ref_clk_in, resetn_in, sample_tick_in, tx_valid_in, tx_pop_out, tx_samp_stb_out;
  logic reg_rd_in, tx_done_out, rx_valid_in, rx_ready_in, rx_samp_ready_out, rx_word_valid_out;
  logic [15:0] tx_word_in, reg_rdata_out, rx_word_out, cnt;
  logic [7:0] reg_addr_in;
  logic [2:0] rx_type_in;
  sbf_tx_samp_t tx_samp_out;
  sbf_rx_samp_t rx_samp_in;
  int n_errors, checks;

  sbf_framer u_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .sample_tick_in(sample_tick_in), .tx_valid_in(tx_valid_in), .tx_word_in(tx_word_in),
    .tx_pop_out(tx_pop_out), .tx_samp_out(tx_samp_out), .tx_samp_stb_out(tx_samp_stb_out),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out),
    .tx_done_out(tx_done_out), .rx_valid_in(rx_valid_in), .rx_type_in(rx_type_in),
    .rx_samp_in(rx_samp_in), .rx_ready_in(rx_ready_in), .rx_samp_ready_out(rx_samp_ready_out),
    .rx_word_valid_out(rx_word_valid_out), .rx_word_out(rx_word_out));

  sbf_host_model u_host (.clk_in(ref_clk_in), .pop_in(tx_pop_out), .rdata_in(reg_rdata_out),
    .tx_valid_out(tx_valid_in), .tx_word_out(tx_word_in), .rd_out(reg_rd_in),
    .addr_out(reg_addr_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // inputs move 2 ns after the rising edge, except the host fifo words, which move at 1 ns
  task automatic step();
    @(posedge ref_clk_in);
    #2;
  endtask

  // one sample period; the bench keeps its own copy of the sample counter
  task automatic tick(output logic stb);
    sample_tick_in = 1'b1;
    step();
    sample_tick_in = 1'b0;
    cnt++;
    stb = tx_samp_stb_out;
  endtask

  // bounded wait: pops come at most every other cycle
  task automatic drain();
    for (int i = 0; i < 40 && u_host.q.size() != 0; i++) step();
    repeat (4) step();
  endtask

  task automatic tx_expect(input logic [15:0] a, input logic [15:0] b, input logic ea, eb);
    logic stb;
    logic [33:0] s, e;
    drain();
    tick(stb);
    chk(stb, 1'b1);
    s = {ea ? tx_samp_out.out_converter_a : 16'h0000, eb ? tx_samp_out.out_converter_b : 16'h0000,
         tx_samp_out.en_a, tx_samp_out.en_b};
    e = {ea ? a : 16'h0000, eb ? b : 16'h0000, ea, eb};
    chk(s, e);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic stb;
    logic [15:0] d;
    u_host.rd(`SBF_SAMPLE_TIME_OFS, d);
    chk(d, cnt);
    repeat (3) tick(stb);
    u_host.rd(`SBF_SAMPLE_TIME_OFS, d);
    chk(d, cnt);
    u_host.rd(8'h30, d);
    chk(d, 16'h0000);
    u_host.rd(`SBF_IRQ_STATUS_OFS, d);
    chk(d, 16'h0000);
  endtask

  // the a only, b only and pair types with their control byte, then a pair sent as bare data bytes
  task automatic t_types();
    logic [2:0] ty;
    logic [15:0] v;
    for (int k = 0; k < 3; k++) begin
      ty = (k == 0) ? `SBF_TX_A_ONLY : (k == 1) ? `SBF_TX_B_ONLY : `SBF_TX_PAIR;
      v = 16'hc3a5 ^ {8'(k), 8'(k)};
      u_host.push({1'b1, 4'h0, ty, v[15:8]});
      u_host.push({8'h00, v[7:0]});
      if (ty == `SBF_TX_PAIR) begin
        u_host.push({8'h00, ~v[15:8]});
        u_host.push({8'h00, ~v[7:0]});
      end
      tx_expect(v, (ty == `SBF_TX_PAIR) ? ~v : v, ty != `SBF_TX_B_ONLY, ty != `SBF_TX_A_ONLY);
    end
    u_host.push(16'h0012);
    u_host.push(16'h0034);
    u_host.push(16'h0056);
    u_host.push(16'h0078);
    tx_expect(16'h1234, 16'h5678, 1'b1, 1'b1);
  endtask

  // a sync fall in mid-count restarts the block; the broken pair is dropped
  task automatic t_resync();
    logic stb;
    u_host.push(16'h00aa);
    u_host.push(16'h00bb);
    u_host.push(16'h8112);
    u_host.push(16'h0034);
    tx_expect(16'h1234, 16'h0000, 1'b1, 1'b0);
    tick(stb);
    chk(stb, 1'b0);
  endtask

  task automatic t_timed();
    logic stb;
    logic [15:0] tgt;
    tgt = cnt + 16'h0003;
    u_host.push({1'b1, 4'h0, `SBF_TX_TIME, tgt[15:8]});
    u_host.push({8'h00, tgt[7:0]});
    u_host.push({1'b1, 4'h0, `SBF_TX_A_ONLY, 8'h5a});
    u_host.push(16'h00c3);
    drain();
    for (int i = 0; i < 4; i++) begin
      tick(stb);
      chk(stb, i == 3);
    end
    chk(tx_samp_out.out_converter_a, 16'h5ac3);
    // bare data words reuse the last type and close at its two-word length
    u_host.push(16'h0011);
    u_host.push(16'h0022);
    tx_expect(16'h1122, 16'h0000, 1'b1, 1'b0);
  endtask

  task automatic t_end();
    logic stb;
    logic [15:0] d;
    u_host.push({1'b1, 4'h0, `SBF_TX_A_ONLY, 8'h3c});
    u_host.push(16'h0042);
    u_host.push({1'b1, 4'h0, `SBF_TX_END, 8'h99});
    drain();
    chk(tx_done_out, 1'b0);
    tick(stb);
    chk(stb, 1'b1);
    drain();
    chk(tx_done_out, 1'b1);
    u_host.rd(`SBF_IRQ_STATUS_OFS, d);
    chk(d, 16'h0001);
    step();
    chk(tx_done_out, 1'b0);
    u_host.rd(`SBF_IRQ_STATUS_OFS, d);
    chk(d, 16'h0000);
  endtask

  // a reset in mid-run drops a waiting sample and restarts the sample counter
  task automatic t_reset();
    logic stb;
    logic [15:0] d;
    u_host.push({1'b1, 4'h0, `SBF_TX_A_ONLY, 8'h77});
    u_host.push(16'h0066);
    drain();
    resetn_in = 1'b0;
    repeat (2) step();
    resetn_in = 1'b1;
    cnt = 16'h0000;
    step();
    chk({tx_done_out, tx_samp_stb_out, rx_word_valid_out, reg_rdata_out}, 34'h0);
    tick(stb);
    chk(stb, 1'b0);
    u_host.rd(`SBF_SAMPLE_TIME_OFS, d);
    chk(d, cnt);
  endtask

  // every receive type, with the fifo stalling one cycle in three
  task automatic t_rx();
    logic [2:0] ty;
    logic [63:0] all;
    logic [15:0] w, m;
    int st, len, got;
    for (int k = 0; k < 7; k++) begin
      ty = (k < 3) ? 3'(k) : 3'(k + 1);
      all = 64'h0123_4567_89ab_cdef ^ {8{8'(k * 17)}};
      st = (ty == 3'h2) ? 2 : (ty == 3'h4 || ty == 3'h5) ? 4 : (ty == 3'h6) ? 6 : 0;
      len = (ty == 3'h7) ? 8 : (ty == 3'h0 || ty == 3'h4) ? 4 : 2;
      chk(rx_samp_ready_out, 1'b1);
      rx_type_in = ty;
      rx_samp_in = all;
      rx_valid_in = 1'b1;
      step();
      rx_valid_in = 1'b0;
      got = 0;
      for (int c = 0; c < 40 && got < len; c++) begin
        rx_ready_in = (c % 3) != 1;
        if (rx_word_valid_out === 1'b1 && rx_ready_in) begin
          w = {(got == 0), (got == 1) ? cnt[6:0] : {4'h0, ty}, all[63 - 8 * (st + got) -: 8]};
          m = (got == 0) ? 16'h87ff : (got == 1) ? 16'hffff : 16'h80ff;
          chk(rx_word_out & m, w & m);
          got++;
        end
        step();
      end
      rx_ready_in = 1'b1;
      chk(34'(got), 34'(len));
      repeat (2) step();
    end
  endtask

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic results();
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the whole run needs a few hundred cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_errors++;
    results();
  end

  initial begin
    n_errors = 0;
    checks = 0;
    cnt = 16'h0000;
    resetn_in = 1'b0;
    sample_tick_in = 1'b0;
    rx_valid_in = 1'b0;
    rx_type_in = 3'h0;
    rx_samp_in = '0;
    rx_ready_in = 1'b1;
    repeat (16) @(posedge ref_clk_in);
    #2;
    resetn_in = 1'b1;
    step();
    t_regs();
    t_types();
    t_resync();
    t_timed();
    t_end();
    t_reset();
    t_rx();
    results();
  end
endmodule
